// ### verilog/asf_pkg.sv
// Constants shared by the alarm and status flag bank
package asf_pkg;

   // Register byte addresses on the serial register port
   localparam logic [7:0] ASF_ADDR_CHAN_ALARM = 8'h70;
   localparam logic [7:0] ASF_ADDR_TEMP_ALARM = 8'h71;
   localparam logic [7:0] ASF_ADDR_GENERAL = 8'h72;

   // Values after reset
   localparam logic [7:0] ASF_RST_CHAN_ALARM = 8'h00;
   localparam logic [7:0] ASF_RST_TEMP_ALARM = 8'h00;
   localparam logic [7:0] ASF_RST_GENERAL = 8'h0c;

   // Field positions, alarm byte 1
   localparam int ASF_BIT_EXT_INPUT = 3;
   localparam int ASF_BIT_OVER_TEMP = 2;
   localparam int ASF_BIT_TEMP_HIGH = 1;
   localparam int ASF_BIT_TEMP_LOW = 0;

   // Field positions, general status byte
   localparam int ASF_BIT_RANGE_LO = 4;
   localparam int ASF_BIT_ADC_IDLE = 3;
   localparam int ASF_BIT_RSVD_ONE = 2;
   localparam int ASF_BIT_GLOBAL = 1;
   localparam int ASF_BIT_DATA_AVAIL = 0;

   // Counts of flags in each alarm byte, and of range groups in the general status byte
   localparam int ASF_NUM_CHAN = 5;
   localparam int ASF_NUM_TEMP = 4;
   localparam int ASF_NUM_GROUP = 4;

   // Data widths
   localparam int ASF_DATA_W = 12;
   localparam int ASF_CONSEC_W = 3;

   // Temperature code scale, milli-degrees per LSB (two's complement)
   localparam int ASF_TEMP_LSB_MDEG = 125;
   localparam int ASF_OVER_TEMP_MDEG = 150000;
   localparam int ASF_HYST_MDEG = 8000;
   localparam logic signed [11:0] ASF_OVER_TEMP_CODE =
      12'(ASF_OVER_TEMP_MDEG / ASF_TEMP_LSB_MDEG);
   localparam logic signed [11:0] ASF_RELEASE_CODE =
      12'((ASF_OVER_TEMP_MDEG - ASF_HYST_MDEG) / ASF_TEMP_LSB_MDEG);

   // Consecutive-sample counter reset value
   localparam logic [2:0] ASF_CNT_RST = 3'h0;

endpackage : asf_pkg

// ### verilog/asf_consec_filter.sv
// Out-of-range filter: trips after N consecutive bad samples
`timescale 1ns/100ps
module asf_consec_filter
   import asf_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Sample stream
   input wire logic sample,
   input wire logic out_of_range,
   input wire logic [ASF_CONSEC_W-1:0] consec_n,
   // Result, one-cycle pulse after a tripping sample
   output logic hit
);

   logic [ASF_CONSEC_W-1:0] cnt_r;
   logic [ASF_CONSEC_W-1:0] cnt_nxt;
   logic hit_r;
   logic hit_nxt;
   logic [ASF_CONSEC_W-1:0] need;
   logic [ASF_CONSEC_W-1:0] cnt_inc;

   always_comb begin
      // A count of zero is treated as one so the alarm can still trip
      need = (consec_n == ASF_CNT_RST) ? ASF_CONSEC_W'(1) : consec_n;
      cnt_inc = (cnt_r == {ASF_CONSEC_W{1'b1}}) ? cnt_r :
         ASF_CONSEC_W'(cnt_r + 1'b1);
      cnt_nxt = cnt_r;
      hit_nxt = 1'b0;
      if (sample) begin
         if (out_of_range) begin
            cnt_nxt = cnt_inc;
            hit_nxt = (cnt_inc >= need);
         end else begin
            cnt_nxt = ASF_CNT_RST;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         cnt_r <= ASF_CNT_RST;
         hit_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         hit_r <= hit_nxt;
      end
   end

   assign hit = hit_r;

endmodule : asf_consec_filter

// ### verilog/asf_status_bank.sv
// Alarm status and general status register bank
`timescale 1ns/100ps
module asf_status_bank
   import asf_pkg::*;
(
   // Clock and synchronous reset (hardware, software or power-on)
   input wire logic clk,
   input wire logic rst_b,
   // Register read port of the serial interface
   input wire logic rd_en,
   input wire logic [7:0] rd_addr,
   output logic [7:0] rd_data,
   output logic rd_valid,
   // Conversion results, one pulse per completed conversion cycle
   input wire logic cycle_done,
   input wire logic [ASF_DATA_W-1:0] chan_result [ASF_NUM_CHAN],
   input wire logic [ASF_DATA_W-1:0] chan_upper [ASF_NUM_CHAN],
   input wire logic [ASF_DATA_W-1:0] chan_lower [ASF_NUM_CHAN],
   input wire logic [ASF_CONSEC_W-1:0] consec_n,
   // Local temperature sensor, two's complement codes
   input wire logic local_temp_sensor_en,
   input wire logic signed [ASF_DATA_W-1:0] temp_reading,
   input wire logic signed [ASF_DATA_W-1:0] temp_upper,
   input wire logic signed [ASF_DATA_W-1:0] temp_lower,
   // External alarm pin
   input wire logic ext_alarm_pin_en,
   input wire logic ext_alarm_pin,
   // Auto-range detect outputs, groups a to d
   input wire logic group_a_range_detect,
   input wire logic group_b_range_detect,
   input wire logic group_c_range_detect,
   input wire logic group_d_range_detect,
   // Sequencer state
   input wire logic adc_running,
   input wire logic direct_mode,
   input wire logic direct_done,
   // Flag levels for the alarm output source logic
   output logic [ASF_NUM_CHAN-1:0] chan_alarm_flags,
   output logic [ASF_NUM_TEMP-1:0] temp_pin_alarm_flags,
   output logic global_alarm
);

   // Flag storage
   logic [ASF_NUM_CHAN-1:0] chan_flag_r;
   logic [ASF_NUM_CHAN-1:0] chan_flag_nxt;
   logic [ASF_NUM_TEMP-1:0] temp_flag_r;
   logic [ASF_NUM_TEMP-1:0] temp_flag_nxt;
   logic global_alarm_r;
   logic global_alarm_nxt;
   logic data_avail_r;
   logic data_avail_nxt;
   logic adc_idle_r;
   logic adc_idle_nxt;
   logic [ASF_NUM_GROUP-1:0] range_r;
   logic [ASF_NUM_GROUP-1:0] range_nxt;
   logic over_temp_cond_r;
   logic over_temp_cond_nxt;

   // Read port
   logic [7:0] rd_data_r;
   logic [7:0] rd_data_nxt;
   logic rd_valid_r;
   logic rd_valid_nxt;

   // Filter results
   logic [ASF_NUM_CHAN-1:0] chan_oor;
   logic [ASF_NUM_CHAN-1:0] chan_hit;
   logic temp_high_hit;
   logic temp_low_hit;
   logic temp_sample;
   logic temp_high_oor;
   logic temp_low_oor;

   // Byte images and read strobes
   logic [7:0] chan_byte;
   logic [7:0] temp_byte;
   logic [7:0] gen_byte;
   logic rd_chan;
   logic rd_temp;
   logic rd_gen;

   // Window test for a unipolar channel, straight binary
   function automatic logic outside_window(
      input logic [ASF_DATA_W-1:0] value,
      input logic [ASF_DATA_W-1:0] upper,
      input logic [ASF_DATA_W-1:0] lower
   );
      outside_window = (value > upper) || (value < lower);
   endfunction : outside_window

   // Pack the flags of one byte into its low bits, rest zero
   function automatic logic [7:0] pad_byte(input logic [4:0] bits,
                                           input int width);
      logic [7:0] b;
      b = 8'h00;
      for (int i = 0; i < 5; i++) begin
         if (i < width) begin
            b[i] = bits[i];
         end
      end
      pad_byte = b;
   endfunction : pad_byte

   // One filter per channel window
   for (genvar g = 0; g < ASF_NUM_CHAN; g++) begin : g_chan
      assign chan_oor[g] =
         outside_window(chan_result[g], chan_upper[g], chan_lower[g]);
      asf_consec_filter u_filt (
         .clk(clk),
         .rst_b(rst_b),
         .sample(cycle_done),
         .out_of_range(chan_oor[g]),
         .consec_n(consec_n),
         .hit(chan_hit[g])
      );
   end

   // Sensor off freezes the limit filters instead of clearing them
   always_comb begin
      temp_sample = cycle_done && local_temp_sensor_en;
      temp_high_oor = (temp_reading > temp_upper);
      temp_low_oor = (temp_reading < temp_lower);
   end

   // Temperature limits share the same filtering
   asf_consec_filter u_temp_high (
      .clk(clk),
      .rst_b(rst_b),
      .sample(temp_sample),
      .out_of_range(temp_high_oor),
      .consec_n(consec_n),
      .hit(temp_high_hit)
   );

   asf_consec_filter u_temp_low (
      .clk(clk),
      .rst_b(rst_b),
      .sample(temp_sample),
      .out_of_range(temp_low_oor),
      .consec_n(consec_n),
      .hit(temp_low_hit)
   );

   // Read decode
   always_comb begin
      rd_chan = rd_en && (rd_addr == ASF_ADDR_CHAN_ALARM);
      rd_temp = rd_en && (rd_addr == ASF_ADDR_TEMP_ALARM);
      rd_gen = rd_en && (rd_addr == ASF_ADDR_GENERAL);
   end

   // Byte images as seen by the host
   always_comb begin
      chan_byte = pad_byte(chan_flag_r, ASF_NUM_CHAN);
      temp_byte = pad_byte({1'b0, temp_flag_r}, ASF_NUM_TEMP);
      gen_byte = 8'h00;
      gen_byte[ASF_BIT_RANGE_LO +: ASF_NUM_GROUP] = range_r;
      gen_byte[ASF_BIT_ADC_IDLE] = adc_idle_r;
      gen_byte[ASF_BIT_RSVD_ONE] = 1'b1;
      gen_byte[ASF_BIT_GLOBAL] = global_alarm_r;
      gen_byte[ASF_BIT_DATA_AVAIL] = data_avail_r;
   end

   // Flag update
   always_comb begin
      chan_flag_nxt = chan_flag_r;
      temp_flag_nxt = temp_flag_r;
      over_temp_cond_nxt = over_temp_cond_r;

      // Read clears the whole byte; a set in the same cycle wins
      if (rd_chan) begin
         chan_flag_nxt = '0;
      end
      if (rd_temp) begin
         temp_flag_nxt = '0;
      end

      // Sets arrive only with a conversion, so a read cannot re-trigger
      chan_flag_nxt = chan_flag_nxt | chan_hit;
      if (temp_high_hit) begin
         temp_flag_nxt[ASF_BIT_TEMP_HIGH] = 1'b1;
      end
      if (temp_low_hit) begin
         temp_flag_nxt[ASF_BIT_TEMP_LOW] = 1'b1;
      end

      // Pin is sampled every clock, it has no conversion to wait for
      if (ext_alarm_pin_en && ext_alarm_pin) begin
         temp_flag_nxt[ASF_BIT_EXT_INPUT] = 1'b1;
      end

      // Over-temperature with hysteresis, judged per conversion
      if (!local_temp_sensor_en) begin
         over_temp_cond_nxt = 1'b0;
      end else if (cycle_done) begin
         if (temp_reading >= ASF_OVER_TEMP_CODE) begin
            over_temp_cond_nxt = 1'b1;
         end else if (temp_reading < ASF_RELEASE_CODE) begin
            over_temp_cond_nxt = 1'b0;
         end
      end
      if (cycle_done && over_temp_cond_nxt) begin
         temp_flag_nxt[ASF_BIT_OVER_TEMP] = 1'b1;
      end
      if (!local_temp_sensor_en) begin
         temp_flag_nxt[ASF_BIT_OVER_TEMP] = 1'b0;
      end
   end

   // General status update
   always_comb begin
      // Held until the general byte is read, set wins over the clear
      global_alarm_nxt = (|chan_flag_r) || (|temp_flag_r) ||
         (global_alarm_r && !rd_gen);
      adc_idle_nxt = !adc_running;
      range_nxt = {group_d_range_detect, group_c_range_detect,
                   group_b_range_detect, group_a_range_detect};
      data_avail_nxt = data_avail_r;
      if (!direct_mode || adc_running) begin
         data_avail_nxt = 1'b0;
      end else if (direct_done) begin
         data_avail_nxt = 1'b1;
      end
   end

   // Read answer, one cycle after the request
   always_comb begin
      rd_valid_nxt = rd_en;
      // Unmapped addresses answer zero, there is no error flag
      rd_data_nxt = 8'h00;
      if (rd_chan) begin
         rd_data_nxt = chan_byte;
      end else if (rd_temp) begin
         rd_data_nxt = temp_byte;
      end else if (rd_gen) begin
         rd_data_nxt = gen_byte;
      end
   end

   // Alarm flag registers
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         chan_flag_r <= ASF_RST_CHAN_ALARM[ASF_NUM_CHAN-1:0];
         temp_flag_r <= ASF_RST_TEMP_ALARM[ASF_NUM_TEMP-1:0];
         over_temp_cond_r <= 1'b0;
      end else begin
         chan_flag_r <= chan_flag_nxt;
         temp_flag_r <= temp_flag_nxt;
         over_temp_cond_r <= over_temp_cond_nxt;
      end
   end

   // General status registers
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         global_alarm_r <= ASF_RST_GENERAL[ASF_BIT_GLOBAL];
         data_avail_r <= ASF_RST_GENERAL[ASF_BIT_DATA_AVAIL];
         adc_idle_r <= ASF_RST_GENERAL[ASF_BIT_ADC_IDLE];
         range_r <= ASF_RST_GENERAL[ASF_BIT_RANGE_LO +: ASF_NUM_GROUP];
      end else begin
         global_alarm_r <= global_alarm_nxt;
         data_avail_r <= data_avail_nxt;
         adc_idle_r <= adc_idle_nxt;
         range_r <= range_nxt;
      end
   end

   // Read answer registers
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         rd_data_r <= 8'h00;
         rd_valid_r <= 1'b0;
      end else begin
         rd_data_r <= rd_data_nxt;
         rd_valid_r <= rd_valid_nxt;
      end
   end

   // Outputs straight from flops
   assign rd_data = rd_data_r;
   assign rd_valid = rd_valid_r;
   assign chan_alarm_flags = chan_flag_r;
   assign temp_pin_alarm_flags = temp_flag_r;
   assign global_alarm = global_alarm_r;

endmodule : asf_status_bank

// ### dv/asf_status_bank_chk.sv
// Port assertions for the alarm and status flag bank
`timescale 1ns/100ps
module asf_status_bank_chk
   import asf_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Read port
   input wire logic rd_en,
   input wire logic [7:0] rd_addr,
   input wire logic [7:0] rd_data,
   input wire logic rd_valid,
   // Alarm sources and flags
   input wire logic cycle_done,
   input wire logic local_temp_sensor_en,
   input wire logic ext_alarm_pin_en,
   input wire logic ext_alarm_pin,
   input wire logic [ASF_NUM_CHAN-1:0] chan_alarm_flags,
   input wire logic [ASF_NUM_TEMP-1:0] temp_pin_alarm_flags,
   input wire logic global_alarm
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);
   logic rd0, rd1, rd2, unm;
   assign rd0 = rd_en && rd_addr == ASF_ADDR_CHAN_ALARM;
   assign rd1 = rd_en && rd_addr == ASF_ADDR_TEMP_ALARM;
   assign rd2 = rd_en && rd_addr == ASF_ADDR_GENERAL;
   assign unm = rd_en && !rd0 && !rd1 && !rd2;
   a_valid_answer: assert property (rd_en |=> rd_valid)
      else $error("read not answered next cycle");
   a_chan_read: assert property (rd0 |=>
      rd_data == {3'h0, $past(chan_alarm_flags)})
      else $error("channel byte read data wrong");
   a_temp_read: assert property (rd1 |=>
      rd_data == {4'h0, $past(temp_pin_alarm_flags)})
      else $error("temperature byte read data wrong");
   a_unmapped_zero: assert property (unm |=> rd_data == 8'h00)
      else $error("unmapped read not zero");
   a_chan_clear: assert property (rd0 && !cycle_done &&
      !$past(cycle_done) |=> chan_alarm_flags == '0)
      else $error("channel flags not cleared by read");
   a_chan_hold: assert property (!rd0 |=>
      (chan_alarm_flags & $past(chan_alarm_flags)) ==
      $past(chan_alarm_flags))
      else $error("channel flag dropped without read");
   a_chan_filtered: assert property (
      (chan_alarm_flags & ~$past(chan_alarm_flags)) != '0
      |-> $past(cycle_done, 2))
      else $error("channel flag rose outside conversion");
   a_ext_set: assert property (ext_alarm_pin_en && ext_alarm_pin
      |=> temp_pin_alarm_flags[ASF_BIT_EXT_INPUT])
      else $error("external flag not set");
   a_otemp_off: assert property (!local_temp_sensor_en [*2]
      |-> !temp_pin_alarm_flags[ASF_BIT_OVER_TEMP])
      else $error("over-temperature flag with sensor off");
   a_global_or: assert property ((|chan_alarm_flags) ||
      (|temp_pin_alarm_flags) |=> global_alarm)
      else $error("global alarm missing");
   a_global_hold: assert property (global_alarm && !rd2
      |=> global_alarm)
      else $error("global alarm dropped without read");
endmodule : asf_status_bank_chk

bind asf_status_bank asf_status_bank_chk u_asf_status_bank_chk (
   .clk(clk), .rst_b(rst_b), .rd_en(rd_en), .rd_addr(rd_addr),
   .rd_data(rd_data), .rd_valid(rd_valid), .cycle_done(cycle_done),
   .local_temp_sensor_en(local_temp_sensor_en),
   .ext_alarm_pin_en(ext_alarm_pin_en), .ext_alarm_pin(ext_alarm_pin),
   .chan_alarm_flags(chan_alarm_flags),
   .temp_pin_alarm_flags(temp_pin_alarm_flags),
   .global_alarm(global_alarm));

// ### dv/asf_host_model.sv
// Serial host side: issues single-byte status reads
`timescale 1ns/100ps
module asf_host_model (
   // Clock
   input wire logic clk,
   // Read port
   output logic rd_en,
   output logic [7:0] rd_addr,
   input wire logic [7:0] rd_data,
   input wire logic rd_valid
);
   initial begin
      rd_en = 1'b0;
      rd_addr = 8'hff;
   end
   // Host reads status bytes to find and release alarms
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      int n;
      @(posedge clk);
      #1 rd_en = 1'b1;
      rd_addr = a;
      @(posedge clk);
      #1 rd_en = 1'b0;
      // Released address never shows its last value
      rd_addr = ~a;
      n = 0;
      while (rd_valid !== 1'b1 && n < 4) begin
         @(posedge clk);
         #1 n++;
      end
      d = (rd_valid === 1'b1) ? rd_data : 8'hxx;
   endtask : rd
endmodule : asf_host_model

// ### dv/asf_status_bank_tb.sv
// Self-checking bench for the alarm and status flag bank
`timescale 1ns/100ps
module asf_status_bank_tb
   import asf_pkg::*;
;
   logic clk, rst_b, rd_en, rd_valid, cycle_done, sen, pen, pin;
   logic ga, gb, gc, gd, adc_running, direct_mode, direct_done, glob;
   logic [7:0] rd_addr, rd_data;
   logic [2:0] consec_n;
   logic [ASF_DATA_W-1:0] res [ASF_NUM_CHAN];
   logic [ASF_DATA_W-1:0] up [ASF_NUM_CHAN];
   logic [ASF_DATA_W-1:0] lo [ASF_NUM_CHAN];
   logic signed [ASF_DATA_W-1:0] t_rd, t_up, t_lo;
   logic [ASF_NUM_CHAN-1:0] cflags;
   logic [ASF_NUM_TEMP-1:0] tflags;
   int err_count = 0;
   int check_count = 0;
   int cyc = 0;
   asf_status_bank u_asf_status_bank (.clk(clk), .rst_b(rst_b),
      .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data),
      .rd_valid(rd_valid), .cycle_done(cycle_done), .chan_result(res),
      .chan_upper(up), .chan_lower(lo), .consec_n(consec_n),
      .local_temp_sensor_en(sen), .temp_reading(t_rd),
      .temp_upper(t_up), .temp_lower(t_lo), .ext_alarm_pin_en(pen),
      .ext_alarm_pin(pin), .group_a_range_detect(ga),
      .group_b_range_detect(gb), .group_c_range_detect(gc),
      .group_d_range_detect(gd), .adc_running(adc_running),
      .direct_mode(direct_mode), .direct_done(direct_done),
      .chan_alarm_flags(cflags), .temp_pin_alarm_flags(tflags),
      .global_alarm(glob));
   asf_host_model u_asf_host_model (.clk(clk), .rd_en(rd_en),
      .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         test_done();
      end
   end
   task automatic test_done();
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : test_done
   task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      u_asf_host_model.rd(a, d);
      check_count++;
      if (d !== exp) begin
         err_count++;
         $display("CHECK FAILED at %0t: %h read %h not %h", $time, a, d,
            exp);
      end
   endtask : rdc
   task automatic outc(input logic [9:0] got, input logic [9:0] exp);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED at %0t: flag pins %h not %h", $time, got,
            exp);
      end
   endtask : outc
   // Two edges after the pulse the flags have landed
   task automatic conv();
      @(posedge clk);
      #1 cycle_done = 1'b1;
      @(posedge clk);
      #1 cycle_done = 1'b0;
      repeat (3) @(posedge clk);
      #1;
   endtask : conv
   task automatic t_reset();
      rdc(8'h70, 8'h00);
      rdc(8'h71, 8'h00);
      rdc(8'h72, 8'h0c);
      rdc(8'h73, 8'h00);
      $display("t_reset done");
   endtask : t_reset
   task automatic t_chan();
      consec_n = 3'h2;
      res[0] = 12'h900;
      conv();
      res[0] = 12'h400;
      conv();
      rdc(8'h70, 8'h00);
      res[2] = 12'h050;
      res[4] = 12'h801;
      conv();
      conv();
      outc({glob, tflags, cflags}, {1'b1, 4'h0, 5'h14});
      rdc(8'h70, 8'h14);
      rdc(8'h70, 8'h00);
      conv();
      rdc(8'h70, 8'h14);
      res[2] = 12'h400;
      res[4] = 12'h400;
      conv();
      rdc(8'h70, 8'h00);
      rdc(8'h72, 8'h0e);
      rdc(8'h72, 8'h0c);
      $display("t_chan done");
   endtask : t_chan
   task automatic t_temp();
      consec_n = 3'h1;
      t_up = 12'h064;
      t_rd = 12'h0c8;
      conv();
      rdc(8'h71, 8'h02);
      t_lo = 12'h000;
      t_rd = 12'hff8;
      conv();
      rdc(8'h71, 8'h01);
      t_up = 12'h7ff;
      t_lo = 12'hc18;
      t_rd = 12'h4b0;
      conv();
      outc({glob, tflags, cflags}, {1'b1, 4'h4, 5'h00});
      rdc(8'h71, 8'h04);
      t_rd = 12'h47e;
      conv();
      rdc(8'h71, 8'h04);
      t_rd = 12'h46a;
      conv();
      rdc(8'h71, 8'h00);
      sen = 1'b0;
      t_rd = 12'h4b0;
      conv();
      rdc(8'h71, 8'h00);
      sen = 1'b1;
      t_rd = 12'h000;
      conv();
      $display("t_temp done");
   endtask : t_temp
   task automatic t_ext();
      pen = 1'b1;
      pin = 1'b1;
      repeat (2) @(posedge clk);
      #1 pin = 1'b0;
      rdc(8'h71, 8'h08);
      rdc(8'h71, 8'h00);
      pen = 1'b0;
      pin = 1'b1;
      rdc(8'h71, 8'h00);
      pin = 1'b0;
      $display("t_ext done");
   endtask : t_ext
   task automatic t_gen();
      rdc(8'h72, 8'h0e);
      ga = 1'b1;
      gc = 1'b1;
      adc_running = 1'b1;
      rdc(8'h72, 8'h54);
      adc_running = 1'b0;
      direct_mode = 1'b1;
      @(posedge clk);
      #1 direct_done = 1'b1;
      @(posedge clk);
      #1 direct_done = 1'b0;
      rdc(8'h72, 8'h5d);
      rdc(8'h72, 8'h5d);
      adc_running = 1'b1;
      rdc(8'h72, 8'h54);
      adc_running = 1'b0;
      @(posedge clk);
      #1 direct_done = 1'b1;
      @(posedge clk);
      #1 direct_done = 1'b0;
      rdc(8'h72, 8'h5d);
      direct_mode = 1'b0;
      {ga, gb, gc, gd} = 4'h5;
      rdc(8'h72, 8'hac);
      $display("t_gen done");
   endtask : t_gen
   initial begin
      rst_b = 1'b0;
      cycle_done = 1'b0;
      consec_n = 3'h1;
      sen = 1'b1;
      {pen, pin, ga, gb, gc, gd} = 6'h00;
      {adc_running, direct_mode, direct_done} = 3'h0;
      t_rd = 12'h000;
      t_up = 12'h7ff;
      t_lo = 12'hc18;
      for (int i = 0; i < ASF_NUM_CHAN; i++) begin
         res[i] = 12'h400;
         up[i] = 12'h800;
         lo[i] = 12'h100;
      end
      repeat (16) @(posedge clk);
      #1 rst_b = 1'b1;
      t_reset();
      t_chan();
      t_temp();
      t_ext();
      t_gen();
      test_done();
   end
endmodule : asf_status_bank_tb
